// File: hdl/pattern_gen_detect.sv
// Shared PRBS / repetitive pattern generator and detector for one of eight framers, AHB-Lite slave.
// Assumes: payload bit strobes come from logic on hclk; far end loops the test channels back.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "prbs_params.svh"
`default_nettype none
module pattern_gen_detect (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire prbs_pkg::payload_bit_s tx_in,
	output logic tx_data_out,
	input wire prbs_pkg::payload_bit_s rx_in,
	output logic [7:0] diag_loopback,
	output logic irq
);
	import prbs_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_idx;
		logic rd_done;
		logic [31:0] rdata;
		logic [7:0] fsel;
		logic [7:0] pctl;
		logic [7:0] slen;
		logic [7:0] tap;
		logic [7:0] einj;
		logic [3:0][7:0] ins;
		logic [7:0] lpbk;
		logic [7:0] txcfg;
		logic [7:0] txidx;
		logic [7:0] txdat;
		logic [7:0] rxcfg;
		logic [7:0] rxidx;
		logic [7:0] rxdat;
		logic [1:0] ien;
		logic [1:0] ist;
		logic [63:0][7:0] tx_tab;
		logic [63:0][7:0] rx_tab;
		logic [31:0] gen;
		logic [31:0] ref_bits;
		logic err_pend;
		logic tx_out;
		det_state_e det;
		logic bef;
		logic [15:0] errcnt;
		logic [5:0] good_cnt;
		logic [5:0] win_cnt;
		logic [3:0] win_err;
	} state_s;

	state_s q, d;

	// ****************************************
	// helpers
	// ****************************************
	// next stream bit from a shift register; repetitive mode simply recirculates
	function automatic logic next_bit(input logic [31:0] s, input logic [4:0] len, input logic [4:0] tp,
			input logic rep);
		next_bit = rep ? s[len] : (s[len] ^ s[tp]);
	endfunction : next_bit

	function automatic logic in_test(input payload_bit_s p, input logic [7:0] fs, input logic [63:0][7:0] tab);
		in_test = p.strobe && (p.framer == fs[6:4]) && tab[p.channel][`ENTRY_TEST];
	endfunction : in_test

	function automatic logic [31:0] shift_in(input logic [31:0] s, input logic b);
		shift_in = {s[30:0], b};
	endfunction : shift_in

	// ****************************************
	// next-state logic
	// ****************************************
	logic wr_en;
	logic rd_en;
	logic [7:0] wb;
	logic gen_bit;
	logic tx_sel;
	logic rx_sel;
	logic rx_bit;
	logic predicted;
	logic mismatch;
	logic sync_change;

	always_comb begin
		d = q;
		wr_en = q.ph_valid && q.ph_write;
		rd_en = q.ph_valid && !q.ph_write && !q.rd_done;
		wb = hwdata[7:0];
		gen_bit = 1'b0;
		tx_sel = in_test(tx_in, q.fsel, q.tx_tab);
		rx_sel = in_test(rx_in, q.fsel, q.rx_tab);
		rx_bit = rx_in.data ^ q.pctl[`PC_RX_INVERT];
		predicted = next_bit(q.ref_bits, q.slen[4:0], q.tap[4:0], q.pctl[`PC_REPETITIVE]);
		mismatch = rx_sel && (rx_bit != predicted);
		sync_change = 1'b0;

		// bus address phase; only word-wide single transfers are expected
		if (hready) begin
			d.ph_valid = hsel && htrans[1] && (haddr[11:10] == 2'b00) && (haddr[1:0] == 2'b00);
			d.ph_write = hwrite;
			d.ph_idx = haddr[9:2];
			d.rd_done = 1'b0;
		end

		// generator: holds between test bits
		if (tx_sel) begin
			gen_bit = next_bit(q.gen, q.slen[4:0], q.tap[4:0], q.pctl[`PC_REPETITIVE]);
			d.gen = shift_in(q.gen, gen_bit);
			d.tx_out = gen_bit ^ q.pctl[`PC_TX_INVERT] ^ q.err_pend;
			d.err_pend = 1'b0;
		end

		// detector
		if (rx_sel) begin
			d.ref_bits = shift_in(q.ref_bits, rx_bit);
			case (q.det)
				DET_HUNT, DET_LOST: begin
					// reference self-loads from the line until a run of correct predictions
					d.good_cnt = mismatch ? 6'h00 : q.good_cnt + 6'h01;
					if (!mismatch && q.good_cnt == `SYNC_GOOD_BITS) begin
						d.det = DET_SYNC;
						d.win_cnt = 6'h00;
						d.win_err = 4'h0;
						sync_change = 1'b1;
					end
				end
				DET_SYNC: begin
					d.ref_bits = shift_in(q.ref_bits, predicted);
					if (mismatch) begin
						d.bef = 1'b1;
						if (q.pctl[`PC_COUNTER_MODE] && q.errcnt != 16'hFFFF) begin
							d.errcnt = q.errcnt + 16'h0001;
						end
						if (q.win_err != 4'hF) begin
							d.win_err = q.win_err + 4'h1;
						end
					end
					d.win_cnt = q.win_cnt + 6'h01;
					if (q.win_cnt == `RESYNC_WINDOW_BITS) begin
						d.win_cnt = 6'h00;
						d.win_err = 4'h0;
						if (q.pctl[`PC_AUTO_RESYNC] && q.win_err >= `RESYNC_ERR_LIMIT) begin
							d.det = DET_LOST;
							d.good_cnt = 6'h00;
							sync_change = 1'b1;
						end
					end
				end
				default: begin
					d.det = DET_HUNT;
				end
			endcase
		end

		// register writes in the data phase
		if (wr_en) begin
			case (q.ph_idx)
				`IDX_FRAMER_SELECT: d.fsel = wb;
				`IDX_PATTERN_CONTROL: d.pctl = wb;
				`IDX_SHIFT_LENGTH: d.slen = wb;
				`IDX_FEEDBACK_TAP: d.tap = wb;
				`IDX_ERROR_INSERT: begin
					// only a 0-to-1 edge of the insert bit arms one error
					if (wb[`EI_INSERT] && !q.einj[`EI_INSERT]) begin
						d.err_pend = 1'b1;
					end
					d.einj = wb;
				end
				`IDX_INSERTION_FIRST, 8'h69, 8'h6A: d.ins[q.ph_idx[1:0]] = wb;
				`IDX_INSERTION_LAST_LOAD: begin
					d.ins[3] = wb;
					d.gen = {wb, q.ins[2], q.ins[1], q.ins[0]};
				end
				`IDX_LOOPBACK_CONTROL: d.lpbk = wb;
				`IDX_TX_PAYLOAD_CONFIG: d.txcfg = wb;
				`IDX_TX_PAYLOAD_DATA: d.txdat = wb;
				`IDX_TX_PAYLOAD_INDEX: begin
					d.txidx = wb;
					if (q.txcfg[`CFG_INDIRECT_EN] && wb[7:6] == 2'b00) begin
						d.tx_tab[wb[5:0]] = q.txdat;
					end
				end
				`IDX_RX_PAYLOAD_CONFIG: d.rxcfg = wb;
				`IDX_RX_PAYLOAD_DATA: d.rxdat = wb;
				`IDX_RX_PAYLOAD_INDEX: begin
					d.rxidx = wb;
					if (q.rxcfg[`CFG_INDIRECT_EN] && wb[7:6] == 2'b00) begin
						d.rx_tab[wb[5:0]] = q.rxdat;
					end
				end
				`IDX_INT_CLEAR: d.ist = q.ist & ~wb[1:0];
				`IDX_INT_ENABLE: d.ien = wb[1:0];
				default: begin
				end
			endcase
		end

		// reads take one wait state so a preceding write is always visible
		if (rd_en) begin
			d.rd_done = 1'b1;
			d.rdata = 32'h0000_0000;
			case (q.ph_idx)
				`IDX_FRAMER_SELECT: d.rdata[7:0] = q.fsel;
				`IDX_PATTERN_CONTROL: d.rdata[7:0] = q.pctl;
				`IDX_PATTERN_STATUS: begin
					d.rdata[`ST_IN_SYNC] = (q.det == DET_SYNC);
					d.rdata[`ST_BIT_ERROR] = q.bef;
					d.bef = 1'b0;
				end
				`IDX_SHIFT_LENGTH: d.rdata[7:0] = q.slen;
				`IDX_FEEDBACK_TAP: d.rdata[7:0] = q.tap;
				`IDX_ERROR_INSERT: d.rdata[7:0] = q.einj;
				`IDX_ERRCNT_LOW: d.rdata[7:0] = q.errcnt[7:0];
				`IDX_ERRCNT_HIGH: d.rdata[7:0] = q.errcnt[15:8];
				`IDX_INSERTION_FIRST, 8'h69, 8'h6A, `IDX_INSERTION_LAST_LOAD: d.rdata[7:0] = q.ins[q.ph_idx[1:0]];
				`IDX_LOOPBACK_CONTROL: d.rdata[7:0] = q.lpbk;
				`IDX_TX_PAYLOAD_CONFIG: d.rdata[7:0] = q.txcfg;
				`IDX_TX_PAYLOAD_INDEX: d.rdata[7:0] = q.txidx;
				`IDX_TX_PAYLOAD_DATA: d.rdata[7:0] = q.txdat;
				`IDX_RX_PAYLOAD_CONFIG: d.rdata[7:0] = q.rxcfg;
				`IDX_RX_PAYLOAD_INDEX: d.rdata[7:0] = q.rxidx;
				`IDX_RX_PAYLOAD_DATA: d.rdata[7:0] = q.rxdat;
				`IDX_INT_STATUS: d.rdata[1:0] = q.ist;
				`IDX_INT_ENABLE: d.rdata[1:0] = q.ien;
				default: d.rdata = 32'h0000_0000;
			endcase
		end

		// a bit error arriving with the status read stays flagged
		if (mismatch && q.det == DET_SYNC) begin
			d.bef = 1'b1;
		end

		// events win over a simultaneous clear
		if (sync_change) begin
			d.ist[`INT_SYNC_CHANGE] = 1'b1;
		end
		if (mismatch && q.det == DET_SYNC) begin
			d.ist[`INT_BIT_ERROR] = 1'b1;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ins <= {4{`RST_INSERTION}};
			q.det <= DET_HUNT;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hreadyout = !(q.ph_valid && !q.ph_write && !q.rd_done);
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	// untested bits pass straight through so live traffic stays in service
	assign tx_data_out = (tx_in.strobe && (tx_in.framer == q.fsel[6:4]) && q.tx_tab[tx_in.channel][`ENTRY_TEST])
		? q.tx_out : tx_in.data;
	assign diag_loopback = q.lpbk[`LB_DIAG_DIGITAL] ? (8'h01 << q.fsel[6:4]) : 8'h00;
	assign irq = |(q.ist & q.ien);
endmodule : pattern_gen_detect
`default_nettype wire

// File: hdl/prbs_params.svh
// Constants for the pattern generator/detector: byte-register indexes, fields, resets, timing.
// Assumes: included by bare name; each index is multiplied by four to form the AHB byte address.
//
// Functional notes
// - PRBS from an LFSR whose feedback tap comes from the tap register.
// - Shift length register holds sequence order minus one.
// - Repetitive select bit 4 repeats insertion words with period length plus one.
// - Separate tx and rx invert flags invert generated and expected pattern.
// - Framer select picks which of eight framers the block serves.
// - Control 82H: results act as error counter, auto resync enabled.
// - Length and tap first, then insertion; last insertion write loads generator.
// - Loopback control 04H puts selected framer in diagnostic digital loopback.
// - Payload config 01H makes per-channel indirect entries reachable.
// - Test data only in chosen channels; other traffic passes untouched.
// - Test bit 08H set per channel via data-then-index sequence.
// - Sync means second status read shows sync 1 and bit error 0.
// - Error insertion 08H then 00H injects exactly one bit error.
`ifndef PRBS_PARAMS_SVH
`define PRBS_PARAMS_SVH

// ****************************************
// register indexes
// ****************************************
`define IDX_FRAMER_SELECT 8'h0F
`define IDX_PATTERN_CONTROL 8'h60
`define IDX_PATTERN_STATUS 8'h61
`define IDX_SHIFT_LENGTH 8'h62
`define IDX_FEEDBACK_TAP 8'h63
`define IDX_ERROR_INSERT 8'h64
`define IDX_ERRCNT_LOW 8'h65
`define IDX_ERRCNT_HIGH 8'h66
`define IDX_INSERTION_FIRST 8'h68
`define IDX_INSERTION_LAST_LOAD 8'h6B
`define IDX_LOOPBACK_CONTROL 8'h8A
`define IDX_TX_PAYLOAD_CONFIG 8'hB0
`define IDX_TX_PAYLOAD_INDEX 8'hB2
`define IDX_TX_PAYLOAD_DATA 8'hB3
`define IDX_RX_PAYLOAD_CONFIG 8'hD0
`define IDX_RX_PAYLOAD_INDEX 8'hD2
`define IDX_RX_PAYLOAD_DATA 8'hD3
`define IDX_INT_STATUS 8'hF0
`define IDX_INT_CLEAR 8'hF1
`define IDX_INT_ENABLE 8'hF2

// ****************************************
// fields
// ****************************************
`define PC_COUNTER_MODE 7
`define PC_RX_INVERT 6
`define PC_TX_INVERT 5
`define PC_REPETITIVE 4
`define PC_AUTO_RESYNC 1
`define ST_IN_SYNC 4
`define ST_BIT_ERROR 2
`define EI_INSERT 3
`define LB_DIAG_DIGITAL 2
`define CFG_INDIRECT_EN 0
`define ENTRY_TEST 3
`define INT_SYNC_CHANGE 0
`define INT_BIT_ERROR 1

// ****************************************
// resets and detector timing
// ****************************************
`define RST_BYTE 8'h00
`define RST_INSERTION 8'hFF
`define SYNC_GOOD_BITS 6'h3F
`define RESYNC_WINDOW_BITS 6'h3F
`define RESYNC_ERR_LIMIT 4'h8

`endif

// File: hdl/prbs_pkg.sv
// Types shared by the pattern generator/detector.
// Assumes: compiled before the design module.
package prbs_pkg;
	typedef struct packed {
		logic strobe;
		logic [2:0] framer;
		logic [5:0] channel;
		logic data;
	} payload_bit_s;

	typedef enum logic [2:0] {
		DET_HUNT = 3'b001,
		DET_SYNC = 3'b010,
		DET_LOST = 3'b100
	} det_state_e;
endpackage : prbs_pkg

// File: sim/pgd_chk.sv
// Port checker for the pattern generator/detector.
// Assumes: bound to the top module, connected by name.
`timescale 1ns/1ps
`default_nettype none
module pgd_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire prbs_pkg::payload_bit_s tx_in,
	input wire logic tx_data_out,
	input wire logic [7:0] diag_loopback
);
	import prbs_pkg::*;
	// ****************************************
	// helpers and properties
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	logic wr_q;
	logic [2:0] sel_q;
	assign take = hsel && hready && htrans[1] && haddr[11:10] == 2'b00 && haddr[1:0] == 2'b00;
	// shadow of the framer choice, so pass-through of other framers can be judged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			sel_q <= 3'h0;
		end else begin
			wr_q <= take && hwrite && haddr == 12'h03C;
			if (wr_q) begin
				sel_q <= hwdata[6:4];
			end
		end
	end
	sequence s_rd;
		take && !hwrite;
	endsequence
	sequence s_lb_wr;
		take && hwrite && haddr == 12'h228;
	endsequence
	a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_read_cause: assert property (!hreadyout |-> $past(take && !hwrite)) else $error("stray wait");
	a_write_ready: assert property (take && hwrite |=> hreadyout) else $error("write waited");
	a_hold_rdata: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("rdata moved");
	a_loop_on: assert property (s_lb_wr ##1 hwdata[2] |=> diag_loopback == (8'h01 << sel_q))
		else $error("loopback not set");
	a_loop_off: assert property (s_lb_wr ##1 !hwdata[2] |=> diag_loopback == 8'h00) else $error("loopback stuck");
	a_loop_onehot: assert property ($onehot0(diag_loopback)) else $error("loopback not one-hot");
	a_pass_idle: assert property (!tx_in.strobe |-> tx_data_out == tx_in.data) else $error("idle bit altered");
	a_pass_other: assert property (tx_in.strobe && tx_in.framer != sel_q |-> tx_data_out == tx_in.data)
		else $error("other framer altered");
endmodule : pgd_chk
`default_nettype wire

// File: sim/payload_far_end.sv
// Far side model: framer payload source plus a line that loops every channel back.
// Assumes: hclk domain; one payload bit every second cycle, 32 channels of 4 bits.
`timescale 1ns/1ps
`default_nettype none
module payload_far_end (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] framer,
	input wire logic tx_data_out,
	output prbs_pkg::payload_bit_s tx_in,
	output prbs_pkg::payload_bit_s rx_in
);
	import prbs_pkg::*;
	logic [7:0] cnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 8'h00;
			tx_in <= '0;
			rx_in <= '0;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			// live traffic keeps toggling so a stuck pass-through shows
			tx_in <= {cnt_q[0], framer, 1'b0, cnt_q[7:3], cnt_q[1] ^ cnt_q[6]};
			rx_in <= {tx_in.strobe, tx_in.framer, tx_in.channel, tx_data_out};
		end
	end
endmodule : payload_far_end
`default_nettype wire

// File: sim/pattern_gen_detect_tb.sv
// Self-checking bench for the pattern generator/detector.
// Assumes: AHB-Lite master here, far side from payload_far_end.
`timescale 1ns/1ps
`include "prbs_params.svh"
`default_nettype none
`define CHK(a, b) check(32'(a), 32'(b))
module pattern_gen_detect_tb;
	import prbs_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_data_out, irq;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, fr;
	logic [31:0] hwdata, hrdata;
	logic [7:0] diag_loopback;
	payload_bit_s tx_in, rx_in;
	int bad_count = 0;
	int total_checks = 0;
	int wd;
	pattern_gen_detect i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_in(tx_in),
		.tx_data_out(tx_data_out), .rx_in(rx_in), .diag_loopback(diag_loopback), .irq(irq));
	payload_far_end i_far (.hclk(hclk), .hresetn(hresetn), .framer(fr),
		.tx_data_out(tx_data_out), .tx_in(tx_in), .rx_in(rx_in));
	// ****************************************
	// bus, compare and closing tasks
	// ****************************************
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask : check
	task automatic finish_test;
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {2'b00, i, 2'b00};
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (!hreadyout);
		q = hrdata[7:0];
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		`CHK(q, e);
	endtask : rdc
	// waits out two test bits of channel 2 so the registered bit is current
	task automatic tbit(input logic e);
		repeat (2) begin
			do @(posedge hclk); while (!(tx_in.strobe && tx_in.channel == 6'd2));
		end
		`CHK(tx_data_out, e);
	endtask : tbit
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rdc(`IDX_PATTERN_CONTROL, 8'h00);
		rdc(`IDX_INSERTION_LAST_LOAD, 8'hFF);
		wr(8'h10, 8'h5A);
		rdc(8'h10, 8'h00);
		`CHK(irq, 1'b0);
		`CHK(hresp, 1'b0);
	endtask : t_reset
	task automatic t_loop;
		wr(`IDX_FRAMER_SELECT, 8'h20);
		rdc(`IDX_FRAMER_SELECT, 8'h20);
		wr(`IDX_LOOPBACK_CONTROL, 8'h04);
		@(posedge hclk);
		`CHK(diag_loopback, 8'h04);
		wr(`IDX_LOOPBACK_CONTROL, 8'h00);
		fr <= 3'd3;
		repeat (100) @(posedge hclk);
		`CHK(diag_loopback, 8'h00);
		fr <= 3'd2;
	endtask : t_loop
	task automatic t_sync;
		logic [7:0] q;
		logic [7:0] ch [3] = '{8'h02, 8'h04, 8'h05};
		wr(`IDX_PATTERN_CONTROL, 8'h82);
		wr(`IDX_SHIFT_LENGTH, 8'h06);
		wr(`IDX_FEEDBACK_TAP, 8'h00);
		wr(`IDX_INSERTION_FIRST, 8'hFF);
		wr(`IDX_INSERTION_LAST_LOAD, 8'hFF);
		wr(`IDX_TX_PAYLOAD_CONFIG, 8'h01);
		wr(`IDX_RX_PAYLOAD_CONFIG, 8'h01);
		foreach (ch[k]) begin
			wr(`IDX_TX_PAYLOAD_DATA, 8'h08);
			wr(`IDX_TX_PAYLOAD_INDEX, ch[k]);
			wr(`IDX_RX_PAYLOAD_DATA, 8'h08);
			wr(`IDX_RX_PAYLOAD_INDEX, ch[k]);
		end
		repeat (6000) @(posedge hclk);
		bus(1'b0, `IDX_PATTERN_STATUS, 8'h00, q);
		bus(1'b0, `IDX_PATTERN_STATUS, 8'h00, q);
		`CHK(q & 8'h14, 8'h10);
		rdc(`IDX_ERRCNT_LOW, 8'h00);
	endtask : t_sync
	task automatic t_errins;
		logic [7:0] q;
		repeat (3) begin
			wr(`IDX_ERROR_INSERT, 8'h08);
			wr(`IDX_ERROR_INSERT, 8'h00);
			repeat (300) @(posedge hclk);
		end
		rdc(`IDX_ERRCNT_LOW, 8'h03);
		bus(1'b0, `IDX_PATTERN_STATUS, 8'h00, q);
		`CHK(q[2], 1'b1);
		wr(`IDX_INT_ENABLE, 8'h02);
		@(posedge hclk);
		`CHK(irq, 1'b1);
		wr(`IDX_INT_ENABLE, 8'h00);
		@(posedge hclk);
		`CHK(irq, 1'b0);
		wr(`IDX_INT_ENABLE, 8'h02);
		wr(`IDX_INT_CLEAR, 8'h02);
		@(posedge hclk);
		`CHK(irq, 1'b0);
	endtask : t_errins
	task automatic t_rep;
		wr(`IDX_PATTERN_CONTROL, 8'h10);
		wr(`IDX_SHIFT_LENGTH, 8'h00);
		wr(`IDX_INSERTION_FIRST, 8'hFE);
		wr(`IDX_INSERTION_LAST_LOAD, 8'hFF);
		tbit(1'b0);
		wr(`IDX_PATTERN_CONTROL, 8'h30);
		tbit(1'b1);
	endtask : t_rep
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		wd = 0;
		forever begin
			@(posedge hclk);
			wd++;
			if (wd == 40000) begin
				bad_count++;
				finish_test();
			end
		end
	end
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'b010;
		fr = 3'd2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_loop();
		t_sync();
		t_errins();
		t_rep();
		finish_test();
	end
endmodule : pattern_gen_detect_tb
bind pattern_gen_detect pgd_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .tx_in(tx_in), .tx_data_out(tx_data_out), .diag_loopback(diag_loopback));
`default_nettype wire
